/* common/core_dp_pkg.sv */
// shared constants, op codes and states for the core datapath
`default_nettype none
package core_dp_pkg;
  // memory sizes
  localparam int PROG_BYTES   = 8192;
  localparam int PROG_AW      = 13;
  localparam int RAM_BYTES    = 256;
  localparam int NVM_BYTES    = 128;
  localparam int NVM_AW       = 7;
  localparam int NVM_PAGES    = 8;
  localparam int NVM_PAGE_LEN = 16;
  localparam int XMEM_AW      = 16;
  // direct address map
  localparam logic [7:0] SFR_BASE      = 8'h80;
  localparam logic [7:0] SFR_SP        = 8'h81;
  localparam logic [7:0] SFR_DPL       = 8'h82;
  localparam logic [7:0] SFR_DPH       = 8'h83;
  localparam logic [7:0] SFR_SECOND_POINTER_LOW      = 8'h84;
  localparam logic [7:0] SFR_SECOND_POINTER_HIGH      = 8'h85;
  localparam logic [7:0] SFR_DPS       = 8'h86;
  localparam logic [7:0] SFR_PSW       = 8'hD0;
  localparam logic [7:0] SFR_ACC       = 8'hE0;
  localparam logic [7:0] SFR_B         = 8'hF0;
  localparam logic [7:0] SFR_NONE_VAL  = 8'hFF;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_LAST = 8'h2F;
  // flag word field positions
  localparam int PSW_CY  = 7;
  localparam int PSW_AC  = 6;
  localparam int PSW_F0  = 5;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV  = 2;
  localparam int PSW_F1  = 1;
  localparam int PSW_P   = 0;
  // reset values
  localparam logic [7:0]  SP_RST  = 8'h07;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [7:0]  B_RST   = 8'h00;
  localparam logic [7:0]  PSW_RST = 8'h00;
  localparam logic [15:0] DP_RST  = 16'h0000;
  localparam logic [7:0]  DPS_RST = 8'h00;

  // operations handed in by the instruction decoder
  typedef enum logic [7:0] {
    OP_NOP      = 8'h00, OP_ADD      = 8'h01, OP_ADDC     = 8'h02,
    OP_SUBB     = 8'h03, OP_AND      = 8'h04, OP_OR       = 8'h05,
    OP_XOR      = 8'h06, OP_MUL      = 8'h07, OP_DIV      = 8'h08,
    OP_LD_DIR   = 8'h09, OP_ST_DIR   = 8'h0A, OP_LD_IND   = 8'h0B,
    OP_ST_IND   = 8'h0C, OP_LD_REG   = 8'h0D, OP_ST_REG   = 8'h0E,
    OP_LD_IMM   = 8'h0F, OP_BIT_SET  = 8'h10, OP_BIT_CLR  = 8'h11,
    OP_PUSH     = 8'h12, OP_POP      = 8'h13, OP_DP_INC   = 8'h14,
    OP_CODE_RD  = 8'h15, OP_XD_RD    = 8'h16, OP_XD_WR    = 8'h17,
    OP_JMP_Z    = 8'h18, OP_JMP_NZ   = 8'h19, OP_JMP_C    = 8'h1A,
    OP_JMP_BIT  = 8'h1B, OP_DP_DEC   = 8'hA5
  } op_code_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XREQ = 2'b01,
    ST_XEND = 2'b10
  } xstate_t;
endpackage : core_dp_pkg
`default_nettype wire

/* hw/core_datapath.sv */
// accumulator datapath with scratch ram, pointers and memory steering
`default_nettype none
// What this block does
// - program and data spaces kept separate
// - instructions fetched from on-chip 8K program store
// - code read uses the same program store
// - external data move spans 64K space
// - 128-byte data flash, 8 pages of 16
// - flash select steers external reads to flash
// - 256-byte scratch ram, direct and indirect
// - special registers only by direct address
// - part of scratch ram is bit addressable
// - decoder ops run through accumulator ALU, jumps
// - second operand register feeds multiply, divide
// - 8-bit flag word holds ALU status
// - 8-bit stack pointer inside scratch ram
// - second 16-bit data pointer in registers
// - op code A5h decrements data pointer
// - four register banks, selected by flag bits
// - bytes 20h to 2Fh also bit addressable
// - push pre-increments, pop post-decrements, reset 07h
module core_datapath (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 op_valid_i,
  input  wire logic [7:0]           op_i,
  input  wire logic [7:0]           op_addr_i,
  input  wire logic [7:0]           op_data_i,
  input  wire logic [15:0]          pc_i,
  input  wire logic                 data_flash_select_i,
  output logic                      busy_o,
  output logic                      op_done_o,
  output logic                      jump_taken_o,
  output logic [15:0]               jump_target_o,
  output logic [7:0]                primary_working_register_o,
  output logic [7:0]                alu_flag_word_o,
  output logic [7:0]                stack_top_pointer_o,
  output logic [15:0]               data_pointer_o,
  input  wire logic [12:0]          fetch_addr_i,
  output logic [7:0]                fetch_data_o,
  input  wire logic                 prog_we_i,
  input  wire logic [12:0]          prog_addr_i,
  input  wire logic [7:0]           prog_data_i,
  input  wire logic                 nvm_we_i,
  input  wire logic [6:0]           nvm_addr_i,
  input  wire logic [7:0]           nvm_data_i,
  output logic                      xmem_req_o,
  output logic                      xmem_we_o,
  output logic [15:0]               xmem_addr_o,
  output logic [7:0]                xmem_wdata_o,
  input  wire logic                 xmem_ack_i,
  input  wire logic [7:0]           xmem_rdata_i
);
  logic [7:0] prog_mem [core_dp_pkg::PROG_BYTES];
  logic [7:0] ram      [core_dp_pkg::RAM_BYTES];
  logic [7:0] nvm      [core_dp_pkg::NVM_BYTES];

  logic [7:0]  acc, next_acc, b, next_b, alu_flag_word, next_psw, sp, next_sp, dps, next_dps;
  logic [15:0] dp0, next_dp0, dp1, next_dp1, xaddr, next_xaddr;
  logic [7:0]  xwdata, next_xwdata;
  logic        xwe, next_xwe, done, next_done, jtaken, next_jtaken;
  logic [15:0] jtarget, next_jtarget;
  logic [7:0]  fetch_q;
  core_dp_pkg::xstate_t state, next_state;
  logic        ack_meta, ack_s;

  // ram write port
  logic        ram_we;
  logic [7:0]  ram_waddr, ram_wdata;
  // direct write request
  logic        dw_en;
  logic [7:0]  dw_addr, dw_data;
  // scratch values
  logic [7:0]  dir_val, bit_byte, bit_val, reg_addr, ind_addr, push_sp, res;
  logic [15:0] dp_act, prod;
  logic [8:0]  wide;
  logic [4:0]  nib;
  logic        cin, sub;
  logic [12:0] code_addr;

  // direct read: ram below 80h, implemented special registers above
  function automatic logic [7:0] dir_read(input logic [7:0] a);
    // special registers on direct path only
    if (a < core_dp_pkg::SFR_BASE) dir_read = ram[a];
    else if (a == core_dp_pkg::SFR_ACC)  dir_read = acc;
    else if (a == core_dp_pkg::SFR_B)    dir_read = b;
    else if (a == core_dp_pkg::SFR_PSW)  dir_read = alu_flag_word;
    else if (a == core_dp_pkg::SFR_SP)   dir_read = sp;
    else if (a == core_dp_pkg::SFR_DPL)  dir_read = dp0[7:0];
    else if (a == core_dp_pkg::SFR_DPH)  dir_read = dp0[15:8];
    else if (a == core_dp_pkg::SFR_SECOND_POINTER_LOW) dir_read = dp1[7:0];
    else if (a == core_dp_pkg::SFR_SECOND_POINTER_HIGH) dir_read = dp1[15:8];
    else if (a == core_dp_pkg::SFR_DPS)  dir_read = dps;
    else dir_read = core_dp_pkg::SFR_NONE_VAL; // missing registers read high
  endfunction

  // bit address to byte address
  function automatic logic [7:0] bit_to_byte(input logic [7:0] ba);
    // low bit space maps onto 20h..2Fh
    if (!ba[7]) bit_to_byte = core_dp_pkg::BIT_AREA_BASE + {4'h0, ba[6:3]};
    else bit_to_byte = {ba[7:3], 3'b000};
  endfunction

  // external acknowledge synchroniser
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_meta <= 1'b0;
      ack_s    <= 1'b0;
    end else begin
      ack_meta <= xmem_ack_i;
      ack_s    <= ack_meta;
    end
  end

  // operation decode and next state
  always_comb begin
    next_acc = acc;  next_b = b;  next_psw = alu_flag_word;  next_sp = sp;  next_dps = dps;
    next_dp0 = dp0;  next_dp1 = dp1;  next_state = state;
    next_xaddr = xaddr;  next_xwdata = xwdata;  next_xwe = xwe;
    next_done = 1'b0;  next_jtaken = 1'b0;  next_jtarget = jtarget;
    ram_we = 1'b0;  ram_waddr = 8'h00;  ram_wdata = 8'h00;
    dw_en = 1'b0;  dw_addr = 8'h00;  dw_data = 8'h00;
    // active pointer picked by select bit
    dp_act   = dps[0] ? dp1 : dp0;
    dir_val  = dir_read(op_addr_i);
    bit_byte = bit_to_byte(op_addr_i);
    bit_val  = dir_read(bit_byte);
    // bank bits pick the register bank
    reg_addr = {3'b000, alu_flag_word[core_dp_pkg::PSW_RS1], alu_flag_word[core_dp_pkg::PSW_RS0], op_addr_i[2:0]};
    // indirect pointer spans all 256 bytes
    ind_addr = ram[{3'b000, alu_flag_word[core_dp_pkg::PSW_RS1], alu_flag_word[core_dp_pkg::PSW_RS0],
                    2'b00, op_addr_i[0]}];
    push_sp  = sp + 8'h01;
    cin      = (op_i == core_dp_pkg::OP_ADD) ? 1'b0 : alu_flag_word[core_dp_pkg::PSW_CY];
    sub      = (op_i == core_dp_pkg::OP_SUBB);
    wide     = sub ? ({1'b0, acc} - {1'b0, op_data_i} - {8'h00, cin})
                   : ({1'b0, acc} + {1'b0, op_data_i} + {8'h00, cin});
    nib      = sub ? ({1'b0, acc[3:0]} - {1'b0, op_data_i[3:0]} - {4'h0, cin})
                   : ({1'b0, acc[3:0]} + {1'b0, op_data_i[3:0]} + {4'h0, cin});
    prod     = acc * b;
    res      = 8'h00;
    // code read indexes program store by pointer plus accumulator
    code_addr = 13'(dp_act + {8'h00, acc});
    case (state)
      core_dp_pkg::ST_IDLE: begin
        if (op_valid_i) begin
          next_done = 1'b1;
          case (op_i)
            core_dp_pkg::OP_ADD, core_dp_pkg::OP_ADDC, core_dp_pkg::OP_SUBB: begin
              next_acc = wide[7:0];
              next_psw[core_dp_pkg::PSW_CY] = wide[8];
              next_psw[core_dp_pkg::PSW_AC] = nib[4];
              next_psw[core_dp_pkg::PSW_OV] = sub
                ? ((acc[7] != op_data_i[7]) && (wide[7] != acc[7]))
                : ((acc[7] == op_data_i[7]) && (wide[7] != acc[7]));
            end
            core_dp_pkg::OP_AND: next_acc = acc & op_data_i;
            core_dp_pkg::OP_OR:  next_acc = acc | op_data_i;
            core_dp_pkg::OP_XOR: next_acc = acc ^ op_data_i;
            core_dp_pkg::OP_MUL: begin
              next_acc = prod[7:0];
              next_b   = prod[15:8];
              next_psw[core_dp_pkg::PSW_CY] = 1'b0;
              next_psw[core_dp_pkg::PSW_OV] = (prod[15:8] != 8'h00);
            end
            core_dp_pkg::OP_DIV: begin
              next_psw[core_dp_pkg::PSW_CY] = 1'b0;
              next_psw[core_dp_pkg::PSW_OV] = (b == 8'h00);
              if (b != 8'h00) begin
                next_acc = acc / b;
                next_b   = acc % b;
              end
            end
            core_dp_pkg::OP_LD_DIR: next_acc = dir_val;
            core_dp_pkg::OP_ST_DIR: begin
              dw_en = 1'b1;  dw_addr = op_addr_i;  dw_data = acc;
            end
            core_dp_pkg::OP_LD_IND: next_acc = ram[ind_addr];
            core_dp_pkg::OP_ST_IND: begin
              ram_we = 1'b1;  ram_waddr = ind_addr;  ram_wdata = acc;
            end
            core_dp_pkg::OP_LD_REG: next_acc = ram[reg_addr];
            core_dp_pkg::OP_ST_REG: begin
              ram_we = 1'b1;  ram_waddr = reg_addr;  ram_wdata = acc;
            end
            core_dp_pkg::OP_LD_IMM: next_acc = op_data_i;
            core_dp_pkg::OP_BIT_SET, core_dp_pkg::OP_BIT_CLR: begin
              res = bit_val;
              res[op_addr_i[2:0]] = (op_i == core_dp_pkg::OP_BIT_SET);
              dw_en = 1'b1;  dw_addr = bit_byte;  dw_data = res;
            end
            core_dp_pkg::OP_PUSH: begin
              next_sp = push_sp;
              ram_we = 1'b1;  ram_waddr = push_sp;  ram_wdata = dir_val;
            end
            core_dp_pkg::OP_POP: begin
              next_sp = sp - 8'h01;
              dw_en = 1'b1;  dw_addr = op_addr_i;  dw_data = ram[sp];
            end
            core_dp_pkg::OP_DP_INC, core_dp_pkg::OP_DP_DEC: begin
              // A5h steps pointer down by one
              if (op_i == core_dp_pkg::OP_DP_DEC) dp_act = dp_act - 16'h0001;
              else dp_act = dp_act + 16'h0001;
              if (dps[0]) next_dp1 = dp_act;
              else next_dp0 = dp_act;
            end
            core_dp_pkg::OP_CODE_RD: next_acc = prog_mem[code_addr];
            core_dp_pkg::OP_XD_RD, core_dp_pkg::OP_XD_WR: begin
              // flash select steers reads to flash
              if (op_i == core_dp_pkg::OP_XD_RD && data_flash_select_i) begin
                // flash offset from low address bits
                next_acc = nvm[dp_act[core_dp_pkg::NVM_AW-1:0]];
              end else begin
                next_done   = 1'b0;
                next_state  = core_dp_pkg::ST_XREQ;
                next_xaddr  = dp_act;
                next_xwdata = acc;
                next_xwe    = (op_i == core_dp_pkg::OP_XD_WR);
              end
            end
            core_dp_pkg::OP_JMP_Z, core_dp_pkg::OP_JMP_NZ,
            core_dp_pkg::OP_JMP_C, core_dp_pkg::OP_JMP_BIT: begin
              next_jtarget = pc_i + {{8{op_data_i[7]}}, op_data_i};
              if (op_i == core_dp_pkg::OP_JMP_Z) next_jtaken = (acc == 8'h00);
              else if (op_i == core_dp_pkg::OP_JMP_NZ) next_jtaken = (acc != 8'h00);
              else if (op_i == core_dp_pkg::OP_JMP_C) next_jtaken = alu_flag_word[core_dp_pkg::PSW_CY];
              else next_jtaken = bit_val[op_addr_i[2:0]];
            end
            default: next_done = 1'b1;
          endcase
        end
      end
      core_dp_pkg::ST_XREQ: begin
        if (ack_s) begin
          if (!xwe) next_acc = xmem_rdata_i;
          next_state = core_dp_pkg::ST_XEND;
        end
      end
      core_dp_pkg::ST_XEND: begin
        if (!ack_s) begin
          next_state = core_dp_pkg::ST_IDLE;
          next_done  = 1'b1;
        end
      end
      default: next_state = core_dp_pkg::ST_IDLE;
    endcase
    // direct writes: ram below 80h, special registers above
    if (dw_en) begin
      if (dw_addr < core_dp_pkg::SFR_BASE) begin
        ram_we = 1'b1;  ram_waddr = dw_addr;  ram_wdata = dw_data;
      end
      else if (dw_addr == core_dp_pkg::SFR_ACC)  next_acc = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_B)    next_b = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_PSW)  next_psw = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_SP)   next_sp = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_DPL)  next_dp0[7:0] = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_DPH)  next_dp0[15:8] = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_SECOND_POINTER_LOW) next_dp1[7:0] = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_SECOND_POINTER_HIGH) next_dp1[15:8] = dw_data;
      else if (dw_addr == core_dp_pkg::SFR_DPS)  next_dps = dw_data;
    end
    next_psw[core_dp_pkg::PSW_P] = ^next_acc;
  end

  // state registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= core_dp_pkg::ACC_RST;  b <= core_dp_pkg::B_RST;  alu_flag_word <= core_dp_pkg::PSW_RST;
      sp  <= core_dp_pkg::SP_RST;   dps <= core_dp_pkg::DPS_RST;
      dp0 <= core_dp_pkg::DP_RST;   dp1 <= core_dp_pkg::DP_RST;
      state <= core_dp_pkg::ST_IDLE;
      xaddr <= 16'h0000;  xwdata <= 8'h00;  xwe <= 1'b0;
      done <= 1'b0;  jtaken <= 1'b0;  jtarget <= 16'h0000;
    end else begin
      acc <= next_acc;  b <= next_b;  alu_flag_word <= next_psw;  sp <= next_sp;  dps <= next_dps;
      dp0 <= next_dp0;  dp1 <= next_dp1;  state <= next_state;
      xaddr <= next_xaddr;  xwdata <= next_xwdata;  xwe <= next_xwe;
      done <= next_done;  jtaken <= next_jtaken;  jtarget <= next_jtarget;
    end
  end

  // memories: scratch ram, program store and data flash
  always_ff @(posedge clk_sys_i) begin
    if (ram_we) ram[ram_waddr] <= ram_wdata;
    if (prog_we_i) prog_mem[prog_addr_i] <= prog_data_i;
    if (nvm_we_i) nvm[nvm_addr_i] <= nvm_data_i;
    fetch_q <= prog_mem[fetch_addr_i];
  end

  assign busy_o                     = (state != core_dp_pkg::ST_IDLE);
  assign op_done_o                  = done;
  assign jump_taken_o               = jtaken;
  assign jump_target_o              = jtarget;
  assign primary_working_register_o = acc;
  assign alu_flag_word_o            = alu_flag_word;
  assign stack_top_pointer_o        = sp;
  assign data_pointer_o             = dps[0] ? dp1 : dp0;
  assign fetch_data_o               = fetch_q;
  assign xmem_req_o                 = (state == core_dp_pkg::ST_XREQ);
  assign xmem_we_o                  = xwe;
  assign xmem_addr_o                = xaddr;
  assign xmem_wdata_o               = xwdata;
endmodule : core_datapath
`default_nettype wire

/* tb/core_datapath_monitor.sv */
// concurrent checks on the datapath ports, bound into the design
`default_nettype none
module core_datapath_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        op_valid_i,
  input wire logic [7:0]  op_i,
  input wire logic [7:0]  op_data_i,
  input wire logic [15:0] pc_i,
  input wire logic        data_flash_select_i,
  input wire logic        busy_o,
  input wire logic        op_done_o,
  input wire logic        jump_taken_o,
  input wire logic [15:0] jump_target_o,
  input wire logic [7:0]  primary_working_register_o,
  input wire logic [7:0]  alu_flag_word_o,
  input wire logic [7:0]  stack_top_pointer_o,
  input wire logic [15:0] data_pointer_o,
  input wire logic        xmem_req_o,
  input wire logic        xmem_we_o,
  input wire logic [15:0] xmem_addr_o,
  input wire logic [7:0]  xmem_wdata_o,
  input wire logic        xmem_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        take;
  logic [15:0] jexp;
  logic [7:0]  acc;
  // helper terms: op accepted, expected jump target
  assign take = op_valid_i && !busy_o;
  assign jexp = pc_i + {{8{op_data_i[7]}}, op_data_i};
  assign acc  = primary_working_register_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  reset_values_a: assert property ($fell(rst_i) |->
    stack_top_pointer_o == 8'h07 && acc == 8'h00)
    else $error("state not at reset values");
  parity_track_a: assert property (alu_flag_word_o[core_dp_pkg::PSW_P] == ^acc)
    else $error("parity flag does not match accumulator");
  add_result_a: assert property (take && op_i == core_dp_pkg::OP_ADD |=>
    op_done_o && acc == 8'($past(acc) + $past(op_data_i)))
    else $error("add result wrong");
  push_step_a: assert property (take && op_i == core_dp_pkg::OP_PUSH |=>
    stack_top_pointer_o == 8'($past(stack_top_pointer_o) + 8'h01))
    else $error("push did not raise stack pointer");
  pop_step_a: assert property (take && op_i == core_dp_pkg::OP_POP |=>
    stack_top_pointer_o == 8'($past(stack_top_pointer_o) - 8'h01))
    else $error("pop did not lower stack pointer");
  step_down_a: assert property (take && op_i == core_dp_pkg::OP_DP_DEC |=>
    data_pointer_o == 16'($past(data_pointer_o) - 16'h0001))
    else $error("pointer step down wrong");
  flash_route_a: assert property (take && op_i == core_dp_pkg::OP_XD_RD &&
    data_flash_select_i |=> op_done_o && !xmem_req_o)
    else $error("flash read went external");
  ext_route_a: assert property (take && (op_i == core_dp_pkg::OP_XD_WR ||
    (op_i == core_dp_pkg::OP_XD_RD && !data_flash_select_i)) |=>
    xmem_req_o && xmem_addr_o == $past(data_pointer_o) &&
    xmem_we_o == ($past(op_i) == core_dp_pkg::OP_XD_WR) &&
    (!xmem_we_o || xmem_wdata_o == $past(acc)))
    else $error("external request wrong");
  req_hold_a: assert property (xmem_req_o && !xmem_ack_i |=> xmem_req_o)
    else $error("request dropped before acknowledge");
  busy_ext_a: assert property (xmem_req_o |-> busy_o)
    else $error("request without busy");
  jump_target_a: assert property (take && op_i == core_dp_pkg::OP_JMP_NZ &&
    acc != 8'h00 |=> jump_taken_o && jump_target_o == $past(jexp))
    else $error("jump not taken or target wrong");
  cov_ext_wr: cover property (xmem_req_o && xmem_we_o && xmem_ack_i);
  cov_flash: cover property (take && op_i == core_dp_pkg::OP_XD_RD && data_flash_select_i);
  cov_jump: cover property (jump_taken_o);
endmodule // core_datapath_monitor
bind core_datapath core_datapath_monitor core_datapath_monitor_inst (.clk_sys_i, .rst_i,
  .op_valid_i, .op_i, .op_data_i, .pc_i, .data_flash_select_i, .busy_o, .op_done_o,
  .jump_taken_o, .jump_target_o, .primary_working_register_o, .alu_flag_word_o,
  .stack_top_pointer_o, .data_pointer_o, .xmem_req_o, .xmem_we_o, .xmem_addr_o,
  .xmem_wdata_o, .xmem_ack_i);
`default_nettype wire

/* tb/ext_mem_model.sv */
// external data memory with four-phase acknowledge and set latency
`default_nettype none
module ext_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [3:0]  delay_i,
  output logic             ack_o,
  output logic [7:0]       rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;
  logic [7:0] last;
  // 64K space, ack held until request falls
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt   <= 4'h0;
      last  <= 8'h00;
    end else if (!req_i) begin
      ack_o <= 1'b0;
      cnt   <= 4'h0;
    end else if (!ack_o) begin
      if (cnt >= delay_i) begin
        ack_o <= 1'b1;
        if (we_i) mem[addr_i] <= wdata_i;
        last <= we_i ? wdata_i : mem[addr_i];
      end else cnt <= cnt + 4'h1;
    end
  end
  // released data lines show the inverse of the last value
  assign rdata_o = ack_o ? mem[addr_i] : ~last;
endmodule // ext_mem_model
`default_nettype wire

/* tb/test_core_datapath.sv */
// self-checking bench for the core datapath and memory steering
`default_nettype none
module test_core_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] op, addr, data, acc;} row_t;
  logic clk_sys_i, rst_i, op_valid_i, data_flash_select_i, prog_we_i, nvm_we_i, xmem_ack_i;
  logic [7:0] op_i, op_addr_i, op_data_i, fetch_data_o, prog_data_i, nvm_data_i, xmem_rdata_i;
  logic [15:0] pc_i, jump_target_o, data_pointer_o, xmem_addr_o;
  logic [12:0] fetch_addr_i, prog_addr_i;
  logic [6:0] nvm_addr_i;
  logic [7:0] primary_working_register_o, alu_flag_word_o, stack_top_pointer_o, xmem_wdata_o;
  logic busy_o, op_done_o, jump_taken_o, xmem_req_o, xmem_we_o;
  logic [3:0] delay;
  int errors, n_compared, cycles, i;
  // ops: 0F ld imm, 01 add, 04 and, 05 or, 06 xor, 03 subb, 0A st dir, 10 bit set, 09 ld dir
  // 0E st reg, 0C st ind, 0B ld ind, 12 push, 13 pop, 07 mul, A5 pointer step down
  row_t rows [30] = '{
    '{8'h0F,8'h00,8'h5A,8'h5A}, '{8'h01,8'h00,8'h0F,8'h69}, '{8'h04,8'h00,8'h0F,8'h09},
    '{8'h05,8'h00,8'hF0,8'hF9}, '{8'h06,8'h00,8'hFF,8'h06}, '{8'h03,8'h00,8'h01,8'h05},
    '{8'h0F,8'h00,8'h00,8'h00}, '{8'h0A,8'h20,8'h00,8'h00}, '{8'h10,8'h03,8'h00,8'h00},
    '{8'h09,8'h20,8'h00,8'h08}, '{8'h0F,8'h00,8'h81,8'h81}, '{8'h0E,8'h00,8'h00,8'h81},
    '{8'h0F,8'h00,8'h55,8'h55}, '{8'h0C,8'h00,8'h00,8'h55}, '{8'h09,8'h81,8'h00,8'h07},
    '{8'h0B,8'h00,8'h00,8'h55}, '{8'h12,8'hE0,8'h00,8'h55}, '{8'h0F,8'h00,8'h00,8'h00},
    '{8'h13,8'hE0,8'h00,8'h55}, '{8'h0F,8'h00,8'h03,8'h03}, '{8'h0A,8'hF0,8'h00,8'h03},
    '{8'h0F,8'h00,8'h07,8'h07}, '{8'h07,8'h00,8'h00,8'h15}, '{8'h0F,8'h00,8'h00,8'h00},
    '{8'h0A,8'h82,8'h00,8'h00}, '{8'h0F,8'h00,8'h01,8'h01}, '{8'h0A,8'h83,8'h00,8'h01},
    '{8'hA5,8'h00,8'h00,8'h01}, '{8'h09,8'h82,8'h00,8'hFF}, '{8'h09,8'h83,8'h00,8'h00}};
  core_datapath core_datapath_inst (.clk_sys_i, .rst_i, .op_valid_i, .op_i, .op_addr_i,
    .op_data_i, .pc_i, .data_flash_select_i, .busy_o, .op_done_o, .jump_taken_o,
    .jump_target_o, .primary_working_register_o, .alu_flag_word_o, .stack_top_pointer_o,
    .data_pointer_o, .fetch_addr_i, .fetch_data_o, .prog_we_i, .prog_addr_i, .prog_data_i,
    .nvm_we_i, .nvm_addr_i, .nvm_data_i, .xmem_req_o, .xmem_we_o, .xmem_addr_o,
    .xmem_wdata_o, .xmem_ack_i, .xmem_rdata_i);
  ext_mem_model ext_mem_model_inst (.clk_sys_i, .rst_i, .req_i(xmem_req_o), .we_i(xmem_we_o),
    .addr_i(xmem_addr_o), .wdata_i(xmem_wdata_o), .delay_i(delay), .ack_o(xmem_ack_i),
    .rdata_o(xmem_rdata_i));
  // clock and cycle ceiling
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // one op from a falling edge, ends at the falling edge where done shows
  task automatic do_op(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
    int k;
    // one idle edge so a following op never re-raises valid in the same step
    @(negedge clk_sys_i);
    op_i = op;
    op_addr_i = a;
    op_data_i = d;
    op_valid_i = 1'b1;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    op_valid_i = 1'b0;
    for (k = 0; k < 40 && op_done_o !== 1'b1; k++) @(negedge clk_sys_i);
    chk({15'h0, op_done_o}, 16'h0001, "op done");
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0; rst_i = 1'b1; op_valid_i = 1'b0; op_i = 8'h00; op_addr_i = 8'h00;
    op_data_i = 8'h00; pc_i = 16'h0000; data_flash_select_i = 1'b0; fetch_addr_i = 13'h0000;
    prog_we_i = 1'b0; prog_addr_i = 13'h0000; prog_data_i = 8'h00; nvm_we_i = 1'b0;
    nvm_addr_i = 7'h00; nvm_data_i = 8'h00; delay = 4'h0;
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk({8'h0, stack_top_pointer_o}, 16'h0007, "reset sp");
    chk({alu_flag_word_o, primary_working_register_o}, 16'h0000, "reset flags");
    chk(data_pointer_o, 16'h0000, "reset pointer");
    $display("test reset done");
    for (i = 0; i < 30; i++) begin
      do_op(rows[i].op, rows[i].addr, rows[i].data);
      chk({8'h0, primary_working_register_o}, {8'h0, rows[i].acc}, "table acc");
    end
    chk(data_pointer_o, 16'h00FF, "step down borrow");
    $display("test table done");
    do_op(8'h0F, 8'h00, 8'h01);
    do_op(8'h0A, 8'h86, 8'h00);
    chk(data_pointer_o, 16'h0000, "second pointer");
    do_op(8'h0F, 8'h00, 8'h00);
    do_op(8'h0A, 8'h86, 8'h00);
    do_op(8'h0F, 8'h00, 8'hA7);
    do_op(8'h17, 8'h00, 8'h00);
    chk({8'h0, ext_mem_model_inst.mem[16'h00FF]}, 16'h00A7, "external write");
    delay = 4'h5;
    do_op(8'h0F, 8'h00, 8'h00);
    do_op(8'h16, 8'h00, 8'h00);
    chk({8'h0, primary_working_register_o}, 16'h00A7, "slow external read");
    $display("test external done");
    nvm_we_i = 1'b1; nvm_addr_i = 7'h7F; nvm_data_i = 8'hC3;
    @(negedge clk_sys_i);
    nvm_we_i = 1'b0; data_flash_select_i = 1'b1;
    do_op(8'h16, 8'h00, 8'h00);
    chk({8'h0, primary_working_register_o}, 16'h00C3, "flash read");
    data_flash_select_i = 1'b0;
    prog_we_i = 1'b1; prog_addr_i = 13'h0100; prog_data_i = 8'h9E;
    @(negedge clk_sys_i);
    prog_we_i = 1'b0; fetch_addr_i = 13'h0100;
    do_op(8'h0F, 8'h00, 8'h01);
    do_op(8'h15, 8'h00, 8'h00);
    chk({8'h0, primary_working_register_o}, 16'h009E, "code read");
    chk({8'h0, fetch_data_o}, 16'h009E, "fetch");
    $display("test flash and code done");
    pc_i = 16'h1000;
    do_op(8'h18, 8'h00, 8'hF0);
    chk({15'h0, jump_taken_o}, 16'h0000, "zero jump on nonzero");
    do_op(8'h19, 8'h00, 8'hF0);
    chk({15'h0, jump_taken_o}, 16'h0001, "nonzero jump");
    chk(jump_target_o, 16'h0FF0, "jump target");
    $display("test jump done");
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk({primary_working_register_o, stack_top_pointer_o}, 16'h0007, "second reset");
    $display("test second reset done");
    close_out();
  end
endmodule // test_core_datapath
`default_nettype wire
